// ===== verilog/csi_defines.svh
// register offsets, bit positions and reset values of the channel source interrupt logic
`ifndef CSI_DEFINES_SVH
`define CSI_DEFINES_SVH

// low address nibble of each per-channel register
`define CSI_OFS_ENABLE 4'h1
`define CSI_OFS_STATUS 4'h2
`define CSI_OFS_ALARM 4'h3

// upper address nibble: channels 0-5 at 0x0-0x5, channels 6-11 at 0x8-0xd
`define CSI_BANK_LO_LAST 4'h5
`define CSI_BANK_HI_FIRST 4'h8
`define CSI_BANK_HI_LAST 4'hd
`define CSI_BANK_HI_SHIFT 4'h2

// source bit positions, shared by enable, status and alarm registers
`define CSI_BIT_LOCK 2
`define CSI_BIT_ABSENT 1
`define CSI_BIT_MONITOR 0

// reset values
`define CSI_ENABLE_RESET 3'h0
`define CSI_STATUS_RESET 3'h0
`define CSI_RDATA_RESET 8'h00

// data returned for an unmapped read
`define CSI_UNMAPPED_DATA 8'h00

`endif

// ===== verilog/csi_pkg.sv
// types of the channel source interrupt logic
`default_nettype none

package csi_pkg;

    // one bit per source: [2] lock change, [1] signal loss change, [0] driver monitor change
    typedef logic [2:0] csi_src_t;

    typedef struct packed {
        logic primed;
        csi_src_t level;
        csi_src_t enable;
        csi_src_t status;
        logic summary;
    } csi_chan_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rd_ack;
    } csi_top_t;

endpackage

`default_nettype wire

// ===== verilog/csi_channel.sv
// per-channel enable, clear-on-read status and summary bit
`timescale 1ns/1ps
`default_nettype none
`include "csi_defines.svh"

module csi_channel (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire csi_pkg::csi_src_t src_level,
    input wire logic enable_wr,
    input wire csi_pkg::csi_src_t enable_wdata,
    input wire logic status_rd,
    output var csi_pkg::csi_src_t enable_q,
    output var csi_pkg::csi_src_t status_q,
    output var csi_pkg::csi_src_t level_q,
    output var logic summary_q
);
    import csi_pkg::*;

    csi_chan_t st_reg;
    csi_chan_t st_next;
    csi_src_t change;

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        change = '0;
        // the first sample after reset only seeds the history, so a source
        // that is already high at reset does not raise a false change
        if (st_reg.primed) begin
            change = src_level ^ st_reg.level;
        end
        st_next.primed = 1'b1;
        st_next.level = src_level;
        if (enable_wr) begin
            st_next.enable = enable_wdata;
        end
        // set wins over the read clear so no change is lost
        st_next.status = (status_rd ? `CSI_STATUS_RESET : st_reg.status)
                         | (change & st_reg.enable);
        st_next.summary = |st_next.status;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= '{primed: 1'b0, level: 3'h0, enable: `CSI_ENABLE_RESET,
                        status: `CSI_STATUS_RESET, summary: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign enable_q = st_reg.enable;
    assign status_q = st_reg.status;
    assign level_q = st_reg.level;
    assign summary_q = st_reg.summary;

    // ==========================================================
    // checks
    sequence s_lock_change;
        st_reg.primed && st_reg.enable[`CSI_BIT_LOCK] && (src_level[`CSI_BIT_LOCK] != st_reg.level[`CSI_BIT_LOCK]);
    endsequence

    enable_store_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        enable_wr |=> enable_q == $past(enable_wdata))
        else $error("enable register did not take written value");

    lock_change_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_lock_change |=> status_q[`CSI_BIT_LOCK] ##1 (status_q[`CSI_BIT_LOCK] || $past(status_rd)))
        else $error("lock change not latched");

    absent_change_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (st_reg.primed && enable_q[`CSI_BIT_ABSENT] && src_level[`CSI_BIT_ABSENT] != level_q[`CSI_BIT_ABSENT])
        |=> status_q[`CSI_BIT_ABSENT])
        else $error("signal loss change not latched");

    monitor_change_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (st_reg.primed && enable_q[`CSI_BIT_MONITOR] && $changed(src_level[`CSI_BIT_MONITOR])
         && src_level[`CSI_BIT_MONITOR] != level_q[`CSI_BIT_MONITOR]) |=> status_q[`CSI_BIT_MONITOR])
        else $error("driver monitor change not latched");

    read_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_rd && (src_level == level_q || !st_reg.primed)) |=> status_q == 3'h0)
        else $error("status not cleared by read");

    masked_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (enable_q == 3'h0 && status_q == 3'h0) |=> status_q == 3'h0)
        else $error("disabled source set its status bit");

    set_over_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_rd && st_reg.primed && enable_q[`CSI_BIT_ABSENT]
         && src_level[`CSI_BIT_ABSENT] != level_q[`CSI_BIT_ABSENT])
        |=> status_q[`CSI_BIT_ABSENT] && summary_q)
        else $error("event lost during status read");

    summary_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (summary_q && !status_rd) |=> summary_q)
        else $error("summary dropped without status read");

endmodule // csi_channel

`default_nettype wire

// ===== verilog/csi_top.sv
// channel source interrupt logic: twelve channels behind the parallel register port
//
// Notes on behaviour
// - enable register at channel base plus one
// - enable bit 2 gates lock change interrupt
// - lock declared or cleared both raise interrupt
// - enable bit 1 gates signal loss change
// - signal loss declared or cleared raises interrupt
// - enable bit 0 gates driver monitor change
// - driver monitor rising or falling raises interrupt
// - status register at channel base plus two
// - status bit 2 latches lock change, read clears
// - status bits 7 to 3 reserved, read zero
// - present lock state readable at alarm bit 2
// - status bit 1 latches signal loss change
// - status bit 0 latches driver monitor change
// - summary bit holds until status register read
`timescale 1ns/1ps
`default_nettype none
`include "csi_defines.svh"

module csi_top #(
    parameter int NUM_CH = 12
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output var logic [7:0] reg_rdata,
    output var logic reg_rd_ack,
    input wire logic [NUM_CH-1:0] clock_recovery_unlocked,
    input wire logic [NUM_CH-1:0] signal_absent_defect,
    input wire logic [NUM_CH-1:0] driver_monitor_output,
    output var logic [NUM_CH-1:0] chan_irq_summary
);
    import csi_pkg::*;

    // ==========================================================
    // parameter check
    // the address map has room for twelve channels and no more
    if (NUM_CH < 1 || NUM_CH > 12) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 12");
    end

    // ==========================================================
    // address decode
    // returns {valid, channel index} for the upper address nibble
    function automatic logic [4:0] chan_decode(input logic [3:0] hi);
        logic [4:0] res;
        res = 5'h00;
        if (hi <= `CSI_BANK_LO_LAST) begin
            res = {1'b1, hi};
        end else if (hi >= `CSI_BANK_HI_FIRST && hi <= `CSI_BANK_HI_LAST) begin
            res = {1'b1, hi - `CSI_BANK_HI_SHIFT};
        end
        if (res[3:0] >= NUM_CH[3:0] && NUM_CH < 16) begin
            res = 5'h00;
        end
        return res;
    endfunction

    logic [4:0] dec;
    logic [3:0] reg_lo;

    assign dec = chan_decode(reg_addr[7:4]);
    assign reg_lo = reg_addr[3:0];

    // ==========================================================
    // channels
    csi_src_t en_arr [NUM_CH];
    csi_src_t st_arr [NUM_CH];
    csi_src_t lvl_arr [NUM_CH];
    logic [NUM_CH-1:0] wr_sel;
    logic [NUM_CH-1:0] rd_clr;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
        assign wr_sel[i] = reg_wr && dec[4] && dec[3:0] == 4'(i) && reg_lo == `CSI_OFS_ENABLE;
        assign rd_clr[i] = reg_rd && dec[4] && dec[3:0] == 4'(i) && reg_lo == `CSI_OFS_STATUS;

        csi_channel u_chan (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .src_level({clock_recovery_unlocked[i], signal_absent_defect[i], driver_monitor_output[i]}),
            .enable_wr(wr_sel[i]),
            .enable_wdata(reg_wdata[2:0]),
            .status_rd(rd_clr[i]),
            .enable_q(en_arr[i]),
            .status_q(st_arr[i]),
            .level_q(lvl_arr[i]),
            .summary_q(chan_irq_summary[i])
        );

        // per-channel view of the map; the fixed-address checks below only cover a few corners
        chan_status_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            rd_clr[i] |=> reg_rd_ack && reg_rdata == {5'h00, $past(st_arr[i])})
            else $error("status read returned wrong channel data");

        chan_enable_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            wr_sel[i] |=> en_arr[i] == $past(reg_wdata[2:0]))
            else $error("enable write missed its channel");

        chan_alarm_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (reg_rd && dec[4] && dec[3:0] == 4'(i) && reg_lo == `CSI_OFS_ALARM)
            |=> reg_rdata == {5'h00, $past(lvl_arr[i])})
            else $error("alarm read returned wrong live levels");

        chan_summary_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            chan_irq_summary[i] == |st_arr[i])
            else $error("summary bit differs from latched status");
    end

    // ==========================================================
    // read path
    csi_top_t st_reg;
    csi_top_t st_next;
    csi_src_t sel_en;
    csi_src_t sel_st;
    csi_src_t sel_lvl;

    always_comb begin
        sel_en = '0;
        sel_st = '0;
        sel_lvl = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            if (dec[3:0] == 4'(k)) begin
                sel_en = en_arr[k];
                sel_st = st_arr[k];
                sel_lvl = lvl_arr[k];
            end
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.rd_ack = reg_rd;
        if (reg_rd) begin
            st_next.rdata = `CSI_UNMAPPED_DATA;
            if (dec[4]) begin
                // upper bits stay zero: reserved fields of all three registers
                case (reg_lo)
                    `CSI_OFS_ENABLE: begin
                        st_next.rdata = {5'h00, sel_en};
                    end
                    `CSI_OFS_STATUS: begin
                        st_next.rdata = {5'h00, sel_st};
                    end
                    `CSI_OFS_ALARM: begin
                        // live levels, not latched; other alarm fields live elsewhere
                        st_next.rdata = {5'h00, sel_lvl};
                    end
                    default: begin
                        st_next.rdata = `CSI_UNMAPPED_DATA;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_reg <= '{rdata: `CSI_RDATA_RESET, rd_ack: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign reg_rd_ack = st_reg.rd_ack;

    // ==========================================================
    // checks
    read_ack_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd_ack == $past(reg_rd))
        else $error("read acknowledge not one cycle after strobe");

    enable_reserved_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && dec[4] && reg_lo == `CSI_OFS_ENABLE) |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved enable bits read nonzero");

    if (NUM_CH == 12) begin : g_map_checks
        sequence s_rd_enable0;
            reg_rd && reg_addr == {4'h0, `CSI_OFS_ENABLE};
        endsequence
        sequence s_rd_status11;
            reg_rd && reg_addr == {4'hd, `CSI_OFS_STATUS};
        endsequence
        sequence s_rd_alarm6;
            reg_rd && reg_addr == {4'h8, `CSI_OFS_ALARM};
        endsequence
        sequence s_wr_enable7;
            reg_wr && reg_addr == {4'h9, `CSI_OFS_ENABLE};
        endsequence

        enable_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            s_rd_enable0 |=> reg_rd_ack && reg_rdata == {5'h00, $past(en_arr[0])})
            else $error("channel 0 enable read wrong");

        enable_write_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            s_wr_enable7 |=> en_arr[7] == $past(reg_wdata[2:0]))
            else $error("channel 7 enable write misrouted");

        status_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            s_rd_status11 |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(st_arr[11]))
            else $error("channel 11 status read wrong");

        alarm_live_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            s_rd_alarm6 |=> reg_rdata[`CSI_BIT_LOCK] == $past(lvl_arr[6][`CSI_BIT_LOCK]))
            else $error("present lock state not readable");

        status_clear_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            s_rd_status11 |-> rd_clr[11] && !rd_clr[10])
            else $error("status read clears wrong channel");

        unmapped_a: assert property (@(posedge clk_sys) disable iff (!resetn)
            (reg_rd && reg_addr[7:4] == 4'h6) |=> reg_rdata == `CSI_UNMAPPED_DATA)
            else $error("unmapped read returned data");
    end

endmodule // csi_top

`default_nettype wire

// ===== verif/csi_host.sv
// host processor model on the parallel register port
`timescale 1ns/1ps
`default_nettype none

module csi_host (
    input wire logic clk_sys,
    output var logic [7:0] reg_addr,
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_ack
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // an idle bus shows inverted junk, so sampling outside a strobe cannot pass by luck
    task automatic release_bus();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        release_bus();
    endtask

    // one-cycle strobe, since a second cycle would read (and clear) again;
    // acknowledge and data stand in the cycle after the strobe and are taken there
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ak);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        ak = reg_rd_ack;
        d = reg_rdata;
        release_bus();
    endtask
endmodule // csi_host

`default_nettype wire

// ===== verif/tb_top.sv
// self-checking testbench of the channel source interrupt logic
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import csi_pkg::*;
    localparam int NCH = 12;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rd_ack;
    logic [NCH-1:0] lk = '0;
    logic [NCH-1:0] sa = '0;
    logic [NCH-1:0] dm = '0;
    logic [NCH-1:0] summ;
    logic [7:0] en_m [NCH];
    logic [7:0] d;
    logic ak;
    logic [2:0] m;
    int ch;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #25 clk_sys = ~clk_sys;

    csi_top #(.NUM_CH(NCH)) dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_ack(reg_rd_ack), .clock_recovery_unlocked(lk), .signal_absent_defect(sa),
        .driver_monitor_output(dm), .chan_irq_summary(summ));

    csi_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack));

    // ==========================================
    // helpers
    function automatic logic [7:0] base(int c);
        return 8'((c < 6 ? c : c + 2) * 16);
    endfunction

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk12(input logic [NCH-1:0] g, input logic [NCH-1:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d, ak);
        chk8({7'h00, ak}, 8'h01);
        chk8(d, e);
    endtask

    task automatic flip(input int c, input logic [2:0] f);
        @(negedge clk_sys);
        lk[c] = lk[c] ^ f[2];
        sa[c] = sa[c] ^ f[1];
        dm[c] = dm[c] ^ f[0];
    endtask

    task automatic stop_test();
        $display("samples_checked %0d n_mismatch %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: the sequence needs about 730 cycles; give up after 2000
    initial begin
        #100_000;
        n_mismatch++;
        stop_test();
    end

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(89033));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        for (int c = 0; c < NCH; c++) begin
            rdc(base(c) | 8'h01, 8'h00);
            rdc(base(c) | 8'h02, 8'h00);
            rdc(base(c) | 8'h03, 8'h00);
        end
        chk12(summ, '0);
        rdc(8'h60, 8'h00);
        rdc(8'h07, 8'h00);
        for (int c = 0; c < NCH; c++) begin
            en_m[c] = (c == 0) ? 8'hff : 8'($urandom);
            host.wr(base(c) | 8'h01, en_m[c]);
        end
        for (int c = 0; c < NCH; c++) begin
            rdc(base(c) | 8'h01, en_m[c] & 8'h07);
        end
        host.wr(base(3) | 8'h02, 8'hff);
        rdc(base(3) | 8'h02, 8'h00);
        // change while disabled must not surface once enabled
        host.wr(base(5) | 8'h01, 8'h00);
        flip(5, 3'h7);
        host.wr(base(5) | 8'h01, 8'h07);
        rdc(base(5) | 8'h02, 8'h00);
        host.wr(base(5) | 8'h01, en_m[5]);
        // change in the very cycle of a status read
        host.wr(base(8) | 8'h01, 8'h07);
        fork
            host.rd(base(8) | 8'h02, d, ak);
            flip(8, 3'h1);
        join
        chk8(d, 8'h00);
        rdc(base(8) | 8'h02, 8'h01);
        host.wr(base(8) | 8'h01, en_m[8]);
        repeat (60) begin
            ch = $urandom_range(NCH - 1);
            m = 3'($urandom);
            flip(ch, m);
            repeat (2) @(negedge clk_sys);
            chk12(summ, NCH'(|(m & en_m[ch][2:0])) << ch);
            rdc(base(ch) | 8'h03, {5'h00, lk[ch], sa[ch], dm[ch]});
            rdc(base(ch) | 8'h02, {5'h00, m & en_m[ch][2:0]});
            rdc(base(ch) | 8'h02, 8'h00);
            chk12(summ, '0);
            if ($urandom_range(3) == 0) begin
                en_m[ch] = 8'($urandom);
                host.wr(base(ch) | 8'h01, en_m[ch]);
            end
        end
        stop_test();
    end
endmodule // tb_top

`default_nettype wire
